// ===== wdt_params.svh
// Constants of the write-once watchdog: register addresses, fields, reset values, keys.
// Assumes inclusion by the package and the design modules of this folder.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_MODE_ADDR        16'hff48
`define WDT_RESTART_ADDR     16'hff49
`define WDT_MODE_RESET       8'h67
`define WDT_RESTART_READ     8'h9a
`define WDT_RESTART_KEY      8'hac
`define WDT_FIXED_BITS       3'h3
`define WDT_CS_HI_BIT        4
`define WDT_CS_LO_BIT        3
`define WDT_PERIOD_LSB       0
`define WDT_PERIOD_MSB       2
`define WDT_LOW_BASE_EXP     11
`define WDT_PERIPH_BASE_EXP  13
`define WDT_STOP_WAIT_TICKS  8
`define WDT_CNT_WIDTH        21

`endif

// ===== wdt_pkg.sv
// Types shared by the watchdog design files.
// Assumes the constants header sits in the same folder.
`include "wdt_params.svh"

package wdt_pkg;

    // Which clock the counter advances on.
    typedef enum logic [1:0] {
        SRC_LOW_SPEED  = 2'b00,
        SRC_PERIPHERAL = 2'b01,
        SRC_STOPPED    = 2'b10
    } clk_src_t;

    // Run state of the counter around standby.
    typedef enum logic [1:0] {
        RUN_ACTIVE  = 2'b00,
        RUN_PAUSED  = 2'b01,
        RUN_RESTART = 2'b10
    } run_state_t;

endpackage

// ===== wdt_tick_edge.sv
// Edge detector turning a sampled clock level into a one-cycle enable pulse.
// Assumes the level input is already synchronous to core_clk.
`timescale 1ns/1ps

module wdt_tick_edge (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Sampled clock level and derived rising-edge pulse.
    input  wire logic level_in,
    output logic      rise_pulse
);

    logic prev_reg;  // Level seen in the previous cycle.

    // Remember the level so a rising edge can be seen.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
        end
    end

    // One pulse per rising edge; registered so it is glitch free.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rise_pulse <= 1'b0;
        end else begin
            rise_pulse <= level_in & ~prev_reg;
        end
    end

endmodule

// ===== wdt_core.sv
// Write-once watchdog timer with mode and restart-key registers on a CPU byte port.
// Assumes the low-speed and peripheral clocks arrive as levels sampled on core_clk,
// and that the CPU port presents one-cycle write and read strobes.
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_core
    import wdt_pkg::*;
#(
    parameter int CNT_WIDTH = `WDT_CNT_WIDTH  // Widest period needs 2^20 counts.
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Clock levels used as count sources, sampled on core_clk.
    input  wire logic       low_speed_osc_clock,
    input  wire logic       periph_clock,
    // Static option and standby status.
    input  wire logic       osc_stoppable,
    input  wire logic       halt_mode,
    input  wire logic       stop_mode,
    input  wire logic       osc_stab_done,
    // CPU byte port.
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_bit_access,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    // Reset request to the reset controller.
    output logic             wdt_reset_req,
    output logic             watchdog_reset_flag
);

    logic [7:0]           watchdog_mode_reg;   // Mode register contents.
    logic                 mode_written_reg;    // Set once the single write is used.
    logic                 stoppable_reg;       // Captured option level.
    logic                 option_armed_reg;    // Cleared once the option is caught.
    logic [CNT_WIDTH-1:0] count_reg;           // Watchdog counter.
    logic [3:0]           wait_cnt_reg;        // Low-speed ticks still to wait after STOP.
    run_state_t           run_state_reg;       // Active, paused, or post-STOP wait.
    logic                 stop_seen_reg;       // Standby was a STOP, not a HALT.
    logic                 low_tick;            // One pulse per low-speed clock edge.
    logic                 periph_tick;         // One pulse per peripheral clock edge.
    clk_src_t             src;                 // Decoded count source.
    logic                 wr_mode;             // Byte write to the mode register.
    logic                 wr_restart;          // Any write to the restart register.
    logic                 key_ok;              // Correct key by byte write.
    logic                 fault;               // Access fault, already muted while stopped.
    logic                 overflow;            // Counter reached its period.
    logic                 standby;             // HALT or STOP in effect.
    logic                 count_tick;          // Counter advances this cycle.
    logic [CNT_WIDTH-1:0] limit;               // Terminal count for the period.

    // Period length in counts: 2^(base + code), shared by both sources.
    function automatic logic [CNT_WIDTH-1:0] period_len(input logic [2:0] code,
                                                        input logic       periph);
        int exp_val;
        exp_val = (periph ? `WDT_PERIPH_BASE_EXP : `WDT_LOW_BASE_EXP) + int'(code);
        period_len = CNT_WIDTH'(1) << exp_val;
    endfunction

    // Edge detectors for the two count clocks.
    wdt_tick_edge low_edge (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .level_in   (low_speed_osc_clock),
        .rise_pulse (low_tick)
    );

    wdt_tick_edge periph_edge (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .level_in   (periph_clock),
        .rise_pulse (periph_tick)
    );

    // Port decode; a bit access never counts as a valid mode write.
    always_comb begin
        wr_mode    = cpu_wr && !cpu_bit_access && (cpu_addr == `WDT_MODE_ADDR);
        wr_restart = cpu_wr && (cpu_addr == `WDT_RESTART_ADDR);
        key_ok     = wr_restart && !cpu_bit_access && (cpu_wdata == `WDT_RESTART_KEY);
        standby    = halt_mode || stop_mode;
    end

    // Source decode: bit 4 stops, bit 3 picks peripheral; fixed if non-stoppable.
    always_comb begin
        if (!stoppable_reg) begin
            src = SRC_LOW_SPEED;
        end else if (watchdog_mode_reg[`WDT_CS_HI_BIT]) begin
            src = SRC_STOPPED;
        end else if (watchdog_mode_reg[`WDT_CS_LO_BIT]) begin
            src = SRC_PERIPHERAL;
        end else begin
            src = SRC_LOW_SPEED;
        end
    end

    // Faults: second mode write, wrong key or bit access to restart; all muted while stopped.
    always_comb begin
        fault = (cpu_wr && (cpu_addr == `WDT_MODE_ADDR) && mode_written_reg)
             || (wr_restart && !key_ok);
        if (src == SRC_STOPPED) begin
            fault = 1'b0;
        end
    end

    // Period and tick selection; standby only gates the stoppable option.
    always_comb begin
        limit = period_len(watchdog_mode_reg[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB],
                           src == SRC_PERIPHERAL);
        case (src)
            SRC_LOW_SPEED:  count_tick = low_tick;
            SRC_PERIPHERAL: count_tick = periph_tick;
            default:        count_tick = 1'b0;
        endcase
        if (stoppable_reg && run_state_reg != RUN_ACTIVE) begin
            count_tick = 1'b0;
        end
        overflow = (src != SRC_STOPPED) && (count_reg >= limit - CNT_WIDTH'(1))
                && count_tick;
    end

    // The option is caught by the first clocked cycle after reset release.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stoppable_reg    <= 1'b0;
            option_armed_reg <= 1'b1;
        end else if (option_armed_reg) begin
            stoppable_reg    <= osc_stoppable;
            option_armed_reg <= 1'b0;
        end
    end

    // Mode register: one byte write accepted; the fixed top bits always read 011.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            watchdog_mode_reg <= `WDT_MODE_RESET;
            mode_written_reg  <= 1'b0;
        end else if (wr_mode && !mode_written_reg) begin
            // Top bits are held at 011 whatever software writes, so a bad
            // value there cannot change behaviour.
            watchdog_mode_reg <= {`WDT_FIXED_BITS, cpu_wdata[4:0]};
            mode_written_reg  <= 1'b1;
        end else if (cpu_wr && cpu_addr == `WDT_MODE_ADDR) begin
            mode_written_reg  <= 1'b1;
        end
    end

    // Standby sequencing: pause in HALT/STOP, then 8 low ticks after STOP.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_state_reg <= RUN_ACTIVE;
            stop_seen_reg <= 1'b0;
            wait_cnt_reg  <= 4'h0;
        end else begin
            case (run_state_reg)
                RUN_ACTIVE: begin
                    if (standby) begin
                        run_state_reg <= RUN_PAUSED;
                        stop_seen_reg <= stop_mode;
                    end
                end
                RUN_PAUSED: begin
                    // HALT resumes at once; STOP must wait for stabilisation.
                    if (stop_mode) begin
                        stop_seen_reg <= 1'b1;
                    end
                    if (!standby) begin
                        if (stop_seen_reg) begin
                            run_state_reg <= RUN_RESTART;
                            wait_cnt_reg  <= 4'(`WDT_STOP_WAIT_TICKS);
                        end else begin
                            run_state_reg <= RUN_ACTIVE;
                        end
                    end
                end
                RUN_RESTART: begin
                    // Wait for stabilisation, then eight low-speed ticks.
                    if (standby) begin
                        run_state_reg <= RUN_PAUSED;
                    end else if (osc_stab_done && low_tick) begin
                        if (wait_cnt_reg == 4'h1) begin
                            run_state_reg <= RUN_ACTIVE;
                        end
                        wait_cnt_reg <= wait_cnt_reg - 4'h1;
                    end
                end
                default: begin
                    run_state_reg <= RUN_ACTIVE;
                end
            endcase
        end
    end

    // Counter: cleared by mode write, key, or overflow; else holds or counts.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (wr_mode && !mode_written_reg) begin
            count_reg <= '0;
        end else if (key_ok) begin
            count_reg <= '0;
        end else if (overflow) begin
            count_reg <= '0;
        end else if (count_tick) begin
            count_reg <= count_reg + CNT_WIDTH'(1);
        end
    end

    // Reset request pulse and the sticky cause flag; the flag lives until
    // system reset clears it, which this block's own reset does.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wdt_reset_req       <= 1'b0;
            watchdog_reset_flag <= 1'b0;
        end else begin
            wdt_reset_req <= (fault || overflow) && !wdt_reset_req;
            if (fault || overflow) begin
                watchdog_reset_flag <= 1'b1;
            end
        end
    end

    // Read data, registered: mode reads back, restart always reads 9AH.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd && cpu_addr == `WDT_MODE_ADDR) begin
            cpu_rdata <= watchdog_mode_reg;
        end else if (cpu_rd && cpu_addr == `WDT_RESTART_ADDR) begin
            cpu_rdata <= `WDT_RESTART_READ;
        end else begin
            cpu_rdata <= 8'h00;
        end
    end

endmodule

// ===== wdt_core_sva.sv
// Port-level checker for the write-once watchdog core.
// Assumes it is bound to wdt_core and that everything runs on core_clk.
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_core_sva #(
    parameter int CNT_WIDTH = 21  // Mirrors the core counter width.
) (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Count sources, option and standby.
    input wire logic        low_speed_osc_clock,
    input wire logic        periph_clock,
    input wire logic        osc_stoppable,
    input wire logic        halt_mode,
    input wire logic        stop_mode,
    input wire logic        osc_stab_done,
    // CPU byte port.
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic        cpu_bit_access,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    // Reset request and flag.
    input wire logic        wdt_reset_req,
    input wire logic        watchdog_reset_flag
);
    logic mode_used;    // The one mode write has been spent.
    logic wdt_stopped;  // That write stopped the watchdog.

    // Shadows the single mode write, since the excuse for access faults depends on it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_used   <= 1'b0;
            wdt_stopped <= 1'b0;
        end else if (cpu_wr && cpu_addr == `WDT_MODE_ADDR && !mode_used) begin
            mode_used   <= 1'b1;
            // A bit access spends the write but stores nothing, so it cannot stop the timer.
            wdt_stopped <= osc_stoppable & cpu_wdata[4] & !cpu_bit_access;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // A write to the restart register, then a bad one.
    sequence s_key_wr;
        cpu_wr && cpu_addr == `WDT_RESTART_ADDR;
    endsequence
    sequence s_key_bad;
        s_key_wr ##0 (cpu_bit_access || cpu_wdata != `WDT_RESTART_KEY);
    endsequence

    property p_bad_key;
        s_key_bad ##0 !wdt_stopped |=> wdt_reset_req;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad restart access gave no reset");
    property p_good_key;
        s_key_wr ##0 (!cpu_bit_access && cpu_wdata == `WDT_RESTART_KEY) |=> !wdt_reset_req;
    endproperty
    a_good_key: assert property (p_good_key) else $error("restart key gave a reset");
    property p_second_mode;
        cpu_wr && cpu_addr == `WDT_MODE_ADDR && mode_used && !wdt_stopped |=> wdt_reset_req;
    endproperty
    a_second_mode: assert property (p_second_mode) else $error("second mode write missed");
    property p_stopped_quiet;
        wdt_stopped |=> !wdt_reset_req;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet) else $error("reset while stopped");
    property p_rd_key;
        cpu_rd && cpu_addr == `WDT_RESTART_ADDR |=> cpu_rdata == `WDT_RESTART_READ;
    endproperty
    a_rd_key: assert property (p_rd_key) else $error("restart read value wrong");
    property p_req_pulse;
        wdt_reset_req |=> !wdt_reset_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
    property p_req_flag;
        wdt_reset_req |-> watchdog_reset_flag;
    endproperty
    a_req_flag: assert property (p_req_flag) else $error("flag not set with request");
    property p_flag_hold;
        watchdog_reset_flag |=> $stable(watchdog_reset_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
endmodule

// ===== testbench.sv
// Self-checking bench for the watchdog core, driving its CPU port and clock levels.
// Assumes the core and its checker are compiled before this file.
`timescale 1ns/1ps
`include "wdt_params.svh"

module testbench;
    // Drives and observed outputs.
    logic        core_clk = 1'b0, rst_n = 1'b0, low_speed_osc_clock = 1'b0;
    logic        osc_stoppable = 1'b1, halt_mode = 1'b0, stop_mode = 1'b0;
    logic        periph_clock = 1'b0, osc_stab_done = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_wr = 1'b0, cpu_rd = 1'b0, cpu_bit_access = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00, cpu_rdata;
    logic        wdt_reset_req, watchdog_reset_flag;
    int          miscompares = 0, check_count = 0, cycles = 0;

    always #12.5 core_clk = ~core_clk;

    // Both count clocks and the stabilisation level are driven, so every source is exercised.
    wdt_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .low_speed_osc_clock(low_speed_osc_clock),
        .periph_clock(periph_clock), .osc_stoppable(osc_stoppable), .halt_mode(halt_mode),
        .stop_mode(stop_mode), .osc_stab_done(osc_stab_done), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_bit_access(cpu_bit_access), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .wdt_reset_req(wdt_reset_req),
        .watchdog_reset_flag(watchdog_reset_flag));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Waits n edges, then lands just after the last one.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset(input logic stoppable);
        rst_n = 1'b0;
        osc_stoppable = stoppable;
        step(2);
        rst_n = 1'b1;
        step(2);
    endtask
    // An idle edge first, so a strobe never drops and rises in one time step.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
        step(1);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_bit_access = b;
        cpu_wr = 1'b1;
        step(1);
        cpu_wr = 1'b0;
        cpu_bit_access = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        step(1);
        cpu_addr = a;
        cpu_rd = 1'b1;
        step(1);
        cpu_rd = 1'b0;
        chk("rdata", exp, cpu_rdata);
    endtask
    // Each tick is a full low-speed period of four core cycles.
    task automatic ticks(input int n);
        repeat (n) begin
            low_speed_osc_clock = 1'b1;
            step(2);
            low_speed_osc_clock = 1'b0;
            step(2);
        end
    endtask
    // Each peripheral tick lasts three core cycles, slower than half the core rate.
    task automatic pticks(input int n);
        repeat (n) begin
            periph_clock = 1'b1;
            step(1);
            periph_clock = 1'b0;
            step(2);
        end
    endtask
    task automatic flag(input logic exp);
        step(4);
        chk("flag", {7'h00, exp}, {7'h00, watchdog_reset_flag});
    endtask

    task automatic t_reset_values;
        do_reset(1'b1);
        rd(`WDT_MODE_ADDR, 8'h67);
        rd(`WDT_RESTART_ADDR, 8'h9a);
        rd(16'h0000, 8'h00);
    endtask
    task automatic t_restart;
        do_reset(1'b1);
        wr(`WDT_RESTART_ADDR, 8'hac, 1'b0);
        flag(1'b0);
        wr(`WDT_RESTART_ADDR, 8'h00, 1'b0);
        chk("req", 8'h01, {7'h00, wdt_reset_req});
        step(1);
        chk("req", 8'h00, {7'h00, wdt_reset_req});
        flag(1'b1);
        do_reset(1'b1);
        wr(`WDT_RESTART_ADDR, 8'hac, 1'b1);
        flag(1'b1);
    endtask
    // A second byte write faults; a bit write to mode stores nothing.
    task automatic t_mode_once;
        do_reset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h61, 1'b0);
        wr(`WDT_MODE_ADDR, 8'h67, 1'b0);
        flag(1'b1);
        rd(`WDT_MODE_ADDR, 8'h61);
        do_reset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h61, 1'b1);
        rd(`WDT_MODE_ADDR, 8'h67);
    endtask
    // Mode write and key both restart the count from zero; the full period then overflows.
    task automatic t_overflow;
        do_reset(1'b1);
        ticks(100);
        wr(`WDT_MODE_ADDR, 8'h60, 1'b0);
        ticks(2047);
        flag(1'b0);
        wr(`WDT_RESTART_ADDR, 8'hac, 1'b0);
        ticks(2047);
        flag(1'b0);
        ticks(1);
        flag(1'b1);
    endtask
    task automatic t_stopped;
        do_reset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h70, 1'b0);
        wr(`WDT_RESTART_ADDR, 8'h00, 1'b0);
        wr(`WDT_RESTART_ADDR, 8'hac, 1'b1);
        wr(`WDT_MODE_ADDR, 8'h67, 1'b0);
        ticks(8);
        flag(1'b0);
        do_reset(1'b0);
        wr(`WDT_MODE_ADDR, 8'h10, 1'b0);
        rd(`WDT_MODE_ADDR, 8'h70);
        wr(`WDT_RESTART_ADDR, 8'h00, 1'b0);
        flag(1'b1);
    endtask
    // Standby: fixed mode counts through STOP; stoppable mode holds the count in HALT,
    // and after STOP waits for stabilisation and then eight uncounted low ticks.
    task automatic t_standby;
        do_reset(1'b0);
        wr(`WDT_MODE_ADDR, 8'h60, 1'b0);
        stop_mode = 1'b1;
        ticks(2048);
        stop_mode = 1'b0;
        flag(1'b1);
        do_reset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h60, 1'b0);
        ticks(1000);
        halt_mode = 1'b1;
        ticks(2048);
        halt_mode = 1'b0;
        step(2);
        ticks(500);
        stop_mode = 1'b1;
        osc_stab_done = 1'b0;
        ticks(10);
        stop_mode = 1'b0;
        ticks(5);
        osc_stab_done = 1'b1;
        ticks(8);
        ticks(547);
        flag(1'b0);
        ticks(1);
        flag(1'b1);
    endtask
    // Peripheral source: low ticks are ignored and the period is 2^13 peripheral ticks.
    task automatic t_periph;
        do_reset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h68, 1'b0);
        rd(`WDT_MODE_ADDR, 8'h68);
        ticks(50);
        pticks(8191);
        flag(1'b0);
        pticks(1);
        flag(1'b1);
    endtask

    task automatic test_done;
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hang short well above the roughly 66400 cycles the tests need.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        do_reset(1'b1);
        t_reset_values();
        t_restart();
        t_mode_once();
        t_overflow();
        t_stopped();
        t_standby();
        t_periph();
        test_done();
    end
endmodule

bind wdt_core wdt_core_sva #(.CNT_WIDTH(CNT_WIDTH)) u_sva (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .low_speed_osc_clock (low_speed_osc_clock),
    .periph_clock        (periph_clock),
    .osc_stoppable       (osc_stoppable),
    .halt_mode           (halt_mode),
    .stop_mode           (stop_mode),
    .osc_stab_done       (osc_stab_done),
    .cpu_addr            (cpu_addr),
    .cpu_wr              (cpu_wr),
    .cpu_rd              (cpu_rd),
    .cpu_bit_access      (cpu_bit_access),
    .cpu_wdata           (cpu_wdata),
    .cpu_rdata           (cpu_rdata),
    .wdt_reset_req       (wdt_reset_req),
    .watchdog_reset_flag (watchdog_reset_flag)
);
